//--- inc/dpsh_pkg.sv
// Constants, commands and states of the dual-port RAM port host controller
package dpsh_pkg;

  // Pin and counter widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 9;
  localparam int CNT_W = 8;

  // Clock period
  localparam int CLK_PERIOD_PS = 4000;

  // Pin timing, nanoseconds as printed for the fastest grade
  localparam int T_WC_NS = 12;
  localparam int T_EW_NS = 10;
  localparam int T_WP_NS = 10;
  localparam int T_WR_NS = 2;
  localparam int T_DW_NS = 10;
  localparam int T_WZ_NS = 10;
  localparam int T_HZ_NS = 10;
  localparam int T_AA_NS = 12;
  localparam int T_SAA_NS = 12;
  localparam int T_SWRD_NS = 5;

  // Least time in ns to whole cycles, rounded up, at least one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // Strobe low time with output drive high
  localparam int WP_PLAIN = max2(max2(T_WP_NS, T_EW_NS), T_DW_NS);
  // Strobe low time if output drive were low during the write
  localparam int WP_OE_LOW = max2(WP_PLAIN, T_WZ_NS + T_DW_NS);

  localparam logic [CNT_W-1:0] WP_CYC = CNT_W'(ns_to_cyc(WP_PLAIN));
  localparam logic [CNT_W-1:0] WP_OE_LOW_CYC = CNT_W'(ns_to_cyc(WP_OE_LOW));
  localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(ns_to_cyc(T_WR_NS));
  localparam logic [CNT_W-1:0] WC_CYC = CNT_W'(ns_to_cyc(T_WC_NS));
  localparam logic [CNT_W-1:0] HZ_CYC = CNT_W'(ns_to_cyc(T_HZ_NS));
  localparam logic [CNT_W-1:0] SWRD_CYC = CNT_W'(ns_to_cyc(T_SWRD_NS));
  // Two extra cycles cover the data input synchroniser
  localparam logic [CNT_W-1:0] SYNC_CYC = 8'h02;
  localparam logic [CNT_W-1:0] AA_CYC = CNT_W'(ns_to_cyc(T_AA_NS)) + SYNC_CYC;
  localparam logic [CNT_W-1:0] SAA_CYC = CNT_W'(ns_to_cyc(T_SAA_NS)) + SYNC_CYC;

  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // Idle pin levels
  localparam logic PIN_HIGH = 1'b1;
  localparam logic PIN_LOW = 1'b0;

  // Semaphore flag read-back bit
  localparam int FLAG_BIT = 0;

  // User commands
  typedef enum logic [1:0] {
    DPSH_ARRAY_WRITE,
    DPSH_ARRAY_READ,
    DPSH_FLAG_WRITE,
    DPSH_FLAG_READ
  } dpsh_cmd_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER,
    ST_ACCESS,
    ST_RELEASE
  } dpsh_state_t;

endpackage : dpsh_pkg

//--- design/dpsh_host.sv
// Host controller driving one port of a dual-port RAM with semaphore flags
// Notes on behaviour
// - Array needs chip select low, flag select high; flags need the reverse.
// - Address changes only while write strobe and selects are high.
// - Host never drives data while the device may be driving.
// - Select combination held stable for the whole select-to-end-of-write time.
// - Output drive held high through every write, so the write pulse is never stretched for driver turn-off.
// - Chip select stays high through flag write and its read-back.
// - At least 5 ns from a flag write to the next flag read.
`timescale 1ns/1ns
module dpsh_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire dpsh_pkg::dpsh_cmd_t cmd,
  input wire logic [dpsh_pkg::ADDR_W-1:0] addr,
  input wire logic [dpsh_pkg::DATA_W-1:0] wdata,
  output logic ready,
  output logic done,
  output logic [dpsh_pkg::DATA_W-1:0] rdata,
  output logic flag_value,
  output logic chip_select_n,
  output logic flag_select_n,
  output logic write_n,
  output logic output_drive_n,
  output logic [dpsh_pkg::ADDR_W-1:0] addr_pin,
  output logic [dpsh_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [dpsh_pkg::DATA_W-1:0] data_in
);
  import dpsh_pkg::*;

  dpsh_state_t state;
  dpsh_cmd_t op;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] flag_gap;
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;
  logic [DATA_W-1:0] wbuf;
  logic is_write;
  logic is_flag;
  logic gap_block;
  logic take;

  assign is_write = (op == DPSH_ARRAY_WRITE) || (op == DPSH_FLAG_WRITE);
  assign is_flag = (op == DPSH_FLAG_WRITE) || (op == DPSH_FLAG_READ);

  // Flag read held off until the write-to-read gap has run out
  assign gap_block = (cmd == DPSH_FLAG_READ) && (flag_gap != CNT_ZERO);
  assign ready = (state == ST_IDLE) && !gap_block;
  assign take = req && ready;

  // Data pin synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_meta <= '0;
      data_sync <= '0;
    end
    else
    begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  // Sequencer for write and read cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      op <= DPSH_ARRAY_READ;
      cnt <= CNT_ZERO;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (take)
          begin
            op <= cmd;
            state <= ST_SETUP;
          end
        end
        ST_SETUP:
        begin
          // Address settled with strobe and selects high
          state <= is_write ? ST_STROBE : ST_ACCESS;
          cnt <= is_write ? WP_CYC : (is_flag ? SAA_CYC : AA_CYC);
        end
        ST_STROBE:
        begin
          if (cnt == CNT_ONE)
          begin
            state <= ST_RECOVER;
            cnt <= WR_CYC;
          end
          else
          begin
            cnt <= cnt - CNT_ONE;
          end
        end
        ST_RECOVER:
        begin
          // Address held past end of write
          if (cnt == CNT_ONE)
          begin
            state <= ST_IDLE;
          end
          else
          begin
            cnt <= cnt - CNT_ONE;
          end
        end
        ST_ACCESS:
        begin
          if (cnt == CNT_ONE)
          begin
            state <= ST_RELEASE;
            cnt <= HZ_CYC;
          end
          else
          begin
            cnt <= cnt - CNT_ONE;
          end
        end
        ST_RELEASE:
        begin
          // Wait for device drivers to float before host may drive
          if (cnt == CNT_ONE)
          begin
            state <= ST_IDLE;
          end
          else
          begin
            cnt <= cnt - CNT_ONE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          cnt <= CNT_ZERO;
        end
      endcase
    end
  end

  // Pin drive from state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_select_n <= PIN_HIGH;
      flag_select_n <= PIN_HIGH;
      write_n <= PIN_HIGH;
      output_drive_n <= PIN_HIGH;
      data_oe <= PIN_LOW;
    end
    else
    begin
      chip_select_n <= PIN_HIGH;
      flag_select_n <= PIN_HIGH;
      write_n <= PIN_HIGH;
      output_drive_n <= PIN_HIGH;
      data_oe <= PIN_LOW;
      if ((state == ST_SETUP) || ((state == ST_STROBE) && (cnt != CNT_ONE)))
      begin
        if (is_write)
        begin
          // Select and strobe fall together, select held for the whole pulse
          chip_select_n <= is_flag;
          flag_select_n <= !is_flag;
          write_n <= PIN_LOW;
          data_oe <= PIN_HIGH;
        end
      end
      if ((state == ST_STROBE) && (cnt == CNT_ONE))
      begin
        // Data held one cycle past the rising strobe
        data_oe <= PIN_HIGH;
      end
      if (((state == ST_SETUP) && !is_write) || ((state == ST_ACCESS) && (cnt != CNT_ONE)))
      begin
        chip_select_n <= is_flag;
        flag_select_n <= !is_flag;
        output_drive_n <= PIN_LOW;
      end
    end
  end

  // Address and write data latched at command time, kept through reset
  // Reset cutting a write must not move the address under the rising strobe
  always_ff @(posedge clk)
  begin
    if (take)
    begin
      addr_pin <= addr;
      wbuf <= wdata;
    end
  end

  assign data_out = wbuf;

  // Gap counter started at end of each flag write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_gap <= CNT_ZERO;
    end
    else if ((state == ST_STROBE) && (cnt == CNT_ONE) && (op == DPSH_FLAG_WRITE))
    begin
      flag_gap <= SWRD_CYC;
    end
    else if (flag_gap != CNT_ZERO)
    begin
      flag_gap <= flag_gap - CNT_ONE;
    end
  end

  // Read capture and completion pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done <= PIN_LOW;
      rdata <= '0;
      flag_value <= PIN_LOW;
    end
    else
    begin
      done <= PIN_LOW;
      if ((state == ST_ACCESS) && (cnt == CNT_ONE))
      begin
        done <= PIN_HIGH;
        rdata <= data_sync;
        if (is_flag)
        begin
          // Flag winner decided by the device, value read back here
          flag_value <= data_sync[FLAG_BIT];
        end
      end
      if ((state == ST_RECOVER) && (cnt == CNT_ONE))
      begin
        done <= PIN_HIGH;
      end
    end
  end

endmodule : dpsh_host

//--- dv/dpsh_host_checker.sv
// Pin timing checks for the dual-port RAM host controller
`timescale 1ns/1ns
module dpsh_host_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic flag_select_n,
  input wire logic write_n,
  input wire logic output_drive_n,
  input wire logic [dpsh_pkg::ADDR_W-1:0] addr_pin,
  input wire logic data_oe
);
  import dpsh_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Strobe low two more cycles with selects held, then high
  sequence s_pulse;
    ##1 (!write_n && $stable(chip_select_n) && $stable(flag_select_n))[*2] ##1 write_n;
  endsequence
  a_one_select: assert property (!(write_n && output_drive_n) |-> chip_select_n != flag_select_n)
    else $error("access without exactly one select low");
  a_addr_quiet: assert property (!$stable(addr_pin) |-> write_n && $past(write_n) && chip_select_n)
    else $error("address moved inside a write");
  a_pulse_held: assert property ($fell(write_n) |-> s_pulse)
    else $error("write pulse short or select moved");
  a_select_with_strobe: assert property ($fell(write_n) |-> $fell(chip_select_n) || $fell(flag_select_n))
    else $error("select did not fall with the strobe");
  a_drive_off_write: assert property (!write_n |-> output_drive_n)
    else $error("output drive low during a write");
  a_host_drive_gap: assert property (data_oe |-> output_drive_n && $past(output_drive_n, 3))
    else $error("host drives data while device may drive");
  a_flag_cs_high: assert property ($fell(flag_select_n) && !write_n |-> chip_select_n[*6])
    else $error("chip select low around a flag write");
  a_flag_read_gap: assert property ($rose(write_n) && !$past(flag_select_n) |-> flag_select_n ##1 flag_select_n)
    else $error("flag read too soon after flag write");
endmodule : dpsh_host_checker
bind dpsh_host dpsh_host_checker i_chk (.clk, .rst_n, .chip_select_n, .flag_select_n, .write_n, .output_drive_n,
  .addr_pin, .data_oe);

//--- dv/dpsh_ram_model.sv
// Behavioural model of one RAM port with semaphore flags
`timescale 1ns/1ns
module dpsh_ram_model (
  input wire logic chip_select_n,
  input wire logic flag_select_n,
  input wire logic write_n,
  input wire logic output_drive_n,
  input wire logic [dpsh_pkg::ADDR_W-1:0] addr_pin,
  input wire logic [dpsh_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  output logic [dpsh_pkg::DATA_W-1:0] data_in
);
  import dpsh_pkg::*;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] flag = 8'hff;
  logic [DATA_W-1:0] last = '0;
  logic [DATA_W-1:0] val;
  wire arr_wr = !chip_select_n && flag_select_n && !write_n;
  wire flg_wr = chip_select_n && !flag_select_n && !write_n;
  wire drv = !output_drive_n && write_n && (chip_select_n != flag_select_n);
  // Store at the end of the strobe overlap
  always @(negedge arr_wr) mem[addr_pin] = data_out;
  // One port only, so no rival write can contend for the flag
  always @(negedge flg_wr) flag[addr_pin[2:0]] = data_out[0];
  // Pin level; released pins show the inverse of the last value
  always @*
  begin
    val = chip_select_n ? {DATA_W{flag[addr_pin[2:0]]}} : mem[addr_pin];
    if (drv) last = val;
    data_in = data_oe ? data_out : (drv ? val : ~last);
  end
endmodule : dpsh_ram_model

//--- dv/dpsh_host_bench.sv
// Self-checking bench for the dual-port RAM host controller
`timescale 1ns/1ns
module dpsh_host_bench;
  import dpsh_pkg::*;
  typedef struct {dpsh_cmd_t cmd; logic [12:0] addr; logic [8:0] wdata; logic [8:0] exp;} dpsh_row_t;
  logic clk = 0, rst_n = 0, req = 0;
  dpsh_cmd_t cmd = DPSH_ARRAY_READ;
  logic [ADDR_W-1:0] addr = '0, addr_pin;
  logic [DATA_W-1:0] wdata = '0, rdata, data_out, data_in;
  logic ready, done, flag_value, chip_select_n, flag_select_n, write_n, output_drive_n, data_oe;
  int fails = 0, n_checks = 0;
  dpsh_row_t rows [9] = '{
    '{DPSH_ARRAY_WRITE, 13'h0000, 9'h1a5, 9'h000},
    '{DPSH_ARRAY_WRITE, 13'h1fff, 9'h05a, 9'h000},
    '{DPSH_ARRAY_READ, 13'h0000, 9'h000, 9'h1a5},
    '{DPSH_ARRAY_READ, 13'h1fff, 9'h000, 9'h05a},
    '{DPSH_FLAG_WRITE, 13'h0003, 9'h000, 9'h000},
    '{DPSH_FLAG_READ, 13'h0003, 9'h000, 9'h000},
    '{DPSH_FLAG_WRITE, 13'h0003, 9'h001, 9'h000},
    '{DPSH_FLAG_READ, 13'h0003, 9'h000, 9'h1ff},
    '{DPSH_FLAG_READ, 13'h0007, 9'h000, 9'h1ff}};
  dpsh_host i_dut (.clk, .rst_n, .req, .cmd, .addr, .wdata, .ready, .done, .rdata, .flag_value, .chip_select_n,
    .flag_select_n, .write_n, .output_drive_n, .addr_pin, .data_out, .data_oe, .data_in);
  dpsh_ram_model i_ram (.chip_select_n, .flag_select_n, .write_n, .output_drive_n, .addr_pin, .data_out,
    .data_oe, .data_in);
  always #2 clk = ~clk;
  // Compare and count
  task check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task results;
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Command set up at a falling edge, request pulsed once the port is ready
  task issue(input dpsh_cmd_t c, input logic [12:0] a, input logic [8:0] d);
    int i;
    i = 0;
    cmd = c;
    addr = a;
    wdata = d;
    @(negedge clk);
    while (!ready && i < 20)
    begin
      @(negedge clk);
      i++;
    end
    if (!ready)
    begin
      fails++;
      results;
    end
    req = 1;
    @(negedge clk);
    req = 0;
  endtask : issue
  // One table command, checked while done stands
  task run(input dpsh_row_t r);
    int i;
    i = 0;
    issue(r.cmd, r.addr, r.wdata);
    while (!done && i < 20)
    begin
      @(negedge clk);
      i++;
    end
    if (!done)
    begin
      fails++;
      results;
    end
    if (r.cmd == DPSH_ARRAY_READ || r.cmd == DPSH_FLAG_READ)
      check(rdata, r.exp);
    if (r.cmd == DPSH_FLAG_READ)
      check(9'(flag_value), 9'(r.exp[0]));
    @(negedge clk);
    check(9'(done), 9'h000);
  endtask : run
  // Reset, table of commands, then the awkward cases
  initial
  begin
    repeat (20) @(negedge clk);
    check(9'({chip_select_n, flag_select_n, write_n, output_drive_n, data_oe, ready, done}), 9'h07a);
    rst_n = 1;
    foreach (rows[k])
      run(rows[k]);
    // Flag read held off through the write-to-read gap, request kept high
    issue(DPSH_FLAG_WRITE, 13'h0005, 9'h000);
    @(negedge clk);
    cmd = DPSH_FLAG_READ;
    req = 1;
    repeat (4) @(negedge clk);
    check(9'({done, ready}), 9'h002);
    @(negedge clk);
    check(9'(ready), 9'h001);
    @(negedge clk);
    req = 0;
    repeat (5) @(negedge clk);
    check(9'(done), 9'h000);
    @(negedge clk);
    check(9'({done, flag_value}), 9'h002);
    check(rdata, 9'h000);
    // Reset in the middle of an array write
    issue(DPSH_ARRAY_WRITE, 13'h00aa, 9'h133);
    @(negedge clk);
    check(9'({chip_select_n, write_n, data_oe}), 9'h001);
    rst_n = 0;
    #1 check(9'({chip_select_n, write_n, data_oe, ready}), 9'h00d);
    @(negedge clk);
    rst_n = 1;
    run(rows[2]);
    results;
  end
endmodule : dpsh_host_bench
